/* File: rtl/dsau_pkg.sv */
/*
 Package for the data space access unit: address map constants and carriers.
 Assumes a single core clock domain and synchronous reset.
*/
package dsau_pkg;
	localparam int DW = 16;
	localparam int PAW = 24;
	localparam logic [15:0] CTRL_LAST = 16'h07FF;
	localparam logic [15:0] NEAR_LAST = 16'h1FFF;
	localparam int NEAR_AW = 13;
	localparam int PVW_BIT = 15;
	localparam logic [15:0] MEM_BYTES = 16'h7800;
	localparam logic [PAW-1:0] RESET_PC = 24'h000000;
	localparam logic [PAW-1:0] RESET_TGT = 24'h000002;
	localparam logic [PAW-1:0] IVT1_FIRST = 24'h000004;
	localparam logic [PAW-1:0] IVT1_LAST = 24'h0000FF;
	localparam logic [PAW-1:0] IVT2_FIRST = 24'h000100;
	localparam logic [PAW-1:0] USER_LAST = 24'h7FFFFF;
	localparam logic [PAW-1:0] PC_STEP = 24'h000002;
	localparam logic [15:0] STEP_BYTE = 16'h0001;
	localparam logic [15:0] STEP_WORD = 16'h0002;
	localparam int TBLPG_TOP = 7;

	typedef enum logic [1:0] {DSAU_IDLE, DSAU_TRAP} dsau_st_e;

	typedef struct packed {
		logic valid;
		logic wr;
		logic byte_op;
		logic [15:0] effective_address;
		logic [15:0] wdata;
		logic bit_rev;
		logic modulo;
	} dsau_req_s;
endpackage

/* File: rtl/dsau_top.sv */
/*
 Data space access unit: program address sequencing, data address decode,
 byte lane steering, X/Y read paths, working register byte rules, and
 misaligned word trap. Assumes the pipeline issues at most one X write and
 one X plus one Y read per cycle; memory arrays are local.
*/
`timescale 1ns/100ps
`default_nettype none
module dsau_top #(
	parameter int MEM_WORDS = 1024,
	parameter int NREGS = 16
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic pc_advance,
	input wire logic pc_reverse,
	input wire logic pc_load,
	input wire logic [dsau_pkg::PAW-1:0] pc_target,
	input wire dsau_pkg::dsau_req_s x_req,
	input wire logic y_rd,
	input wire logic [15:0] y_addr,
	input wire logic near_direct,
	input wire logic [dsau_pkg::NEAR_AW-1:0] near_field,
	input wire logic [15:0] ptr_in,
	input wire logic [3:0] wreg_sel,
	input wire logic wreg_we,
	input wire logic wreg_byte,
	input wire logic sign_extend_op,
	input wire logic zero_extend_op,
	input wire logic [15:0] wreg_wdata,
	input wire logic tbl_op,
	input wire logic [7:0] table_page_pointer,
	input wire logic [dsau_pkg::PAW-1:0] prog_req_addr,
	output logic [dsau_pkg::PAW-1:0] pc_q,
	output logic pc_in_vector_q,
	output logic [15:0] x_rdata_q,
	output logic [15:0] y_rdata_q,
	output logic prog_visibility_window_q,
	output logic [15:0] ptr_next_q,
	output logic [15:0] wreg_rdata_q,
	output logic prog_access_ok_q,
	output logic addr_error_trap_q
);
	import dsau_pkg::*;

	logic [7:0] mem_lo [MEM_WORDS];
	logic [7:0] mem_hi [MEM_WORDS];
	logic [15:0] wreg [NREGS];
	logic [PAW-1:0] pc_d;
	logic [15:0] x_rdata_d, y_rdata_d, ptr_next_d, wreg_rdata_d;
	logic pvw_d, vec_d, pok_d, trap_d, misalign;
	logic [15:0] x_ea;
	logic [15:0] wr_ea;
	logic [1:0] lane_we;
	dsau_st_e st_q, st_d;

	// Address counts as implemented when below the window and within the array
	function automatic logic implemented(input logic [15:0] ea);
		implemented = !ea[PVW_BIT] && (ea < MEM_BYTES) && (32'(ea[15:1]) < MEM_WORDS);
	endfunction

	// Word read with zero fill outside the array
	function automatic logic [15:0] word_at(input logic [15:0] ea,
			input logic [7:0] lo, input logic [7:0] hi);
		word_at = implemented(ea) ? {hi, lo} : 16'h0000;
	endfunction

	// Bit-reversal of the word index for X writes only
	function automatic logic [15:0] bitrev(input logic [15:0] ea);
		logic [15:0] r;
		r = 16'h0000;
		for (int i = 1; i < 16; i++)
			r[i] = ea[16 - i];
		bitrev = r;
	endfunction

	// Near direct field zero-extends; move class uses full 16-bit EA
	assign x_ea = near_direct ? {{(16-NEAR_AW){1'b0}}, near_field} : x_req.effective_address;
	// Write generator is separate from the read path
	assign wr_ea = x_req.bit_rev ? bitrev(x_ea) : x_ea;
	assign misalign = x_req.valid && !x_req.byte_op && x_ea[0];
	always_comb
	begin
		lane_we = 2'b00;
		if (x_req.valid && x_req.wr && !misalign && implemented(wr_ea))
		begin
			if (x_req.byte_op)
				lane_we = wr_ea[0] ? 2'b10 : 2'b01;
			else
				lane_we = 2'b11;
		end
	end

	always_comb
	begin
		pc_d = pc_q;
		if (pc_load)
			pc_d = {pc_target[PAW-1:1], 1'b0};
		else if (pc_advance)
			pc_d = pc_reverse ? pc_q - PC_STEP : pc_q + PC_STEP;
		vec_d = (pc_d >= IVT1_FIRST && pc_d <= IVT1_LAST) ||
			(pc_d >= IVT2_FIRST && pc_d < IVT2_FIRST + IVT2_FIRST);
		pok_d = (prog_req_addr <= USER_LAST) || (tbl_op && table_page_pointer[TBLPG_TOP]);
		pvw_d = x_req.valid && x_ea[PVW_BIT];
		x_rdata_d = x_rdata_q;
		if (x_req.valid && !x_req.wr)
		begin
			x_rdata_d = word_at(x_ea, mem_lo[x_ea[15:1] % MEM_WORDS], mem_hi[x_ea[15:1] % MEM_WORDS]);
			if (x_req.byte_op)
				x_rdata_d = {8'h00, x_ea[0] ? x_rdata_d[15:8] : x_rdata_d[7:0]};
		end
		y_rdata_d = y_rd ? word_at(y_addr, mem_lo[y_addr[15:1] % MEM_WORDS],
			mem_hi[y_addr[15:1] % MEM_WORDS]) : y_rdata_q;
		ptr_next_d = ptr_in + (x_req.byte_op ? STEP_BYTE : STEP_WORD);
		wreg_rdata_d = wreg[wreg_sel];
		// Trap raised for one cycle per misaligned word access; a misaligned write is blocked, a read still returns data
		st_d = misalign ? DSAU_TRAP : DSAU_IDLE;
		trap_d = misalign;
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			pc_q <= RESET_PC;
			pc_in_vector_q <= 1'b0;
			x_rdata_q <= 16'h0000;
			y_rdata_q <= 16'h0000;
			prog_visibility_window_q <= 1'b0;
			ptr_next_q <= 16'h0000;
			wreg_rdata_q <= 16'h0000;
			prog_access_ok_q <= 1'b0;
			addr_error_trap_q <= 1'b0;
			st_q <= DSAU_IDLE;
		end
		else
		begin
			pc_q <= pc_d;
			pc_in_vector_q <= vec_d;
			x_rdata_q <= x_rdata_d;
			y_rdata_q <= y_rdata_d;
			prog_visibility_window_q <= pvw_d;
			ptr_next_q <= ptr_next_d;
			wreg_rdata_q <= wreg_rdata_d;
			prog_access_ok_q <= pok_d;
			addr_error_trap_q <= trap_d;
			st_q <= st_d;
		end
	end

	// Arrays carry no reset; contents are undefined until written
	always_ff @(posedge sys_clk)
	begin
		if (lane_we[0])
			mem_lo[wr_ea[15:1] % MEM_WORDS] <= x_req.wdata[7:0];
		if (lane_we[1])
			mem_hi[wr_ea[15:1] % MEM_WORDS] <= x_req.wdata[15:8];
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			for (int i = 0; i < NREGS; i++)
				wreg[i] <= 16'h0000;
		end
		else if (sign_extend_op)
			wreg[wreg_sel] <= {{8{wreg_wdata[7]}}, wreg_wdata[7:0]};
		else if (zero_extend_op)
			wreg[wreg_sel] <= {8'h00, wreg_wdata[7:0]};
		else if (wreg_we)
			wreg[wreg_sel] <= wreg_byte ? {wreg[wreg_sel][15:8], wreg_wdata[7:0]} : wreg_wdata;
	end

	pc_even_a: assert property (@(posedge sys_clk) disable iff (srst) pc_q[0] == 1'b0)
		else $error("pc odd");
	pc_step_a: assert property (@(posedge sys_clk) disable iff (srst)
		pc_advance && !pc_load && !pc_reverse |=> pc_q == $past(pc_q) + PC_STEP)
		else $error("pc step wrong");
	trap_pulse_a: assert property (@(posedge sys_clk) disable iff (srst)
		misalign |=> addr_error_trap_q)
		else $error("trap missing");
	trap_word_a: assert property (@(posedge sys_clk) disable iff (srst)
		addr_error_trap_q |-> $past(!x_req.byte_op && x_req.valid))
		else $error("trap on byte access");
	misw_block_a: assert property (@(posedge sys_clk) disable iff (srst)
		misalign |-> lane_we == 2'b00)
		else $error("misaligned write done");
	byte_lane_a: assert property (@(posedge sys_clk) disable iff (srst)
		x_req.byte_op |-> lane_we != 2'b11)
		else $error("byte wrote both lanes");
	ptr_step_a: assert property (@(posedge sys_clk) disable iff (srst)
		x_req.byte_op |=> ptr_next_q == $past(ptr_in) + STEP_BYTE)
		else $error("pointer step wrong");
	byte_read_a: assert property (@(posedge sys_clk) disable iff (srst)
		x_req.valid && !x_req.wr && x_req.byte_op |=> x_rdata_q[15:8] == 8'h00)
		else $error("byte read high nonzero");
	pvw_zero_a: assert property (@(posedge sys_clk) disable iff (srst)
		x_req.valid && !x_req.wr && x_ea[PVW_BIT] |=> x_rdata_q == 16'h0000)
		else $error("window read nonzero");
	// Reset is checked outside the disable so the start address is really seen
	reset_pc_a: assert property (@(posedge sys_clk)
		srst |=> pc_q == RESET_PC && !addr_error_trap_q)
		else $error("pc not at reset address");
	vec_flag_a: assert property (@(posedge sys_clk) disable iff (srst)
		pc_in_vector_q |-> pc_q >= IVT1_FIRST && pc_q < IVT2_FIRST + IVT2_FIRST)
		else $error("vector flag outside tables");
	pok_user_a: assert property (@(posedge sys_clk) disable iff (srst)
		prog_req_addr <= USER_LAST |=> prog_access_ok_q)
		else $error("user program access refused");
	pok_block_a: assert property (@(posedge sys_clk) disable iff (srst)
		prog_req_addr > USER_LAST && !tbl_op |=> !prog_access_ok_q)
		else $error("upper program access allowed");
	pvw_flag_a: assert property (@(posedge sys_clk) disable iff (srst)
		x_req.valid && x_ea[PVW_BIT] |=> prog_visibility_window_q)
		else $error("window flag missing");
	word_lanes_a: assert property (@(posedge sys_clk) disable iff (srst)
		x_req.valid && x_req.wr && !x_req.byte_op && !misalign && implemented(wr_ea)
		|-> lane_we == 2'b11)
		else $error("word write lost a lane");
	ptr_word_a: assert property (@(posedge sys_clk) disable iff (srst)
		!x_req.byte_op |=> ptr_next_q == $past(ptr_in) + STEP_WORD)
		else $error("word pointer step wrong");
endmodule // dsau_top
`default_nettype wire

/* File: test/dsau_pipe_model.sv */
/* Pipeline-side data space model: byte mirror of X/Y memory, expected reads.
 Assumes one X access per cycle and MW equal to the design's MEM_WORDS. */
`timescale 1ns/100ps
`default_nettype none
module dsau_pipe_model #(parameter int MW = 64) (
	input wire logic sys_clk,
	input wire dsau_pkg::dsau_req_s x_req,
	input wire logic [15:0] y_addr,
	output logic [15:0] exp_x,
	output logic [15:0] exp_y,
	output logic exp_ok,
	output logic exp_trap
);
	import dsau_pkg::*;
	logic [7:0] m [2*MW];
	logic [15:0] a;
	function automatic logic inr(input logic [15:0] e);
		return !e[PVW_BIT] && e < MEM_BYTES && e < 2*MW;
	endfunction
	function automatic logic [15:0] rd(input logic [15:0] e, input logic b);
		logic [15:0] w;
		w = inr(e) ? {m[e | 16'h0001], m[e & 16'hFFFE]} : 16'h0000;
		return b ? {8'h00, e[0] ? w[15:8] : w[7:0]} : w;
	endfunction
	assign a = x_req.effective_address;
	assign exp_trap = x_req.valid && !x_req.byte_op && a[0];
	assign exp_ok = !exp_trap;
	always_comb
	begin
		exp_x = rd(a, x_req.byte_op);
		exp_y = rd(y_addr, 1'b0);
	end
	// Misaligned words never reach the array, so later reads expose a leak
	always @(posedge sys_clk)
	begin
		if (x_req.valid && x_req.wr && !exp_trap && inr(a))
		begin
			m[a] <= x_req.wdata[7:0];
			if (!x_req.byte_op)
				m[a | 16'h0001] <= x_req.wdata[15:8];
		end
	end
endmodule // dsau_pipe_model
`default_nettype wire

/* File: test/tb_top.sv */
/* Bench for dsau_top: memory fill, then random X/Y, PC, pointer, register traffic.
 Assumes dsau_pipe_model mirrors the data space. */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import dsau_pkg::*;
	localparam int MW = 64;
	logic sys_clk = 1'b0, srst = 1'b1, live = 1'b0;
	logic pc_advance = 1'b0, pc_reverse = 1'b0, pc_load = 1'b0, y_rd = 1'b0;
	logic wreg_we = 1'b0, wreg_byte = 1'b0, sign_extend_op = 1'b0, zero_extend_op = 1'b0;
	logic [23:0] pc_target = '0, pc_q, pc_r;
	dsau_req_s x_req = '0;
	logic [15:0] y_addr = '0, ptr_in = '0, wreg_wdata = '0, x_rdata_q, y_rdata_q;
	logic [15:0] ptr_next_q, wreg_rdata_q, exp_x, exp_y, pe, wx, d;
	logic [15:0] wr_r [16];
	logic [3:0] wreg_sel = '0;
	logic pc_in_vector_q, pvw_q, pa_ok_q, addr_error_trap_q, exp_ok, exp_trap;
	logic xp = 1'b0, yp = 1'b0, tp = 1'b0, wp = 1'b0;
	logic tbl_op = 1'b0, ok_e = 1'b0, pv_e = 1'b0;
	logic [7:0] tpp = '0;
	logic [23:0] pra = '0;
	logic [15:0] xq [$], yq [$];
	int fail_count = 0, n_compared = 0, seed = 32'hfdab54ef, i;
	logic [31:0] r, r2;
	always #4 sys_clk = ~sys_clk;
	dsau_top #(.MEM_WORDS(MW), .NREGS(16)) dsau_top_inst (.sys_clk(sys_clk), .srst(srst),
		.pc_advance(pc_advance), .pc_reverse(pc_reverse), .pc_load(pc_load),
		.pc_target(pc_target), .x_req(x_req), .y_rd(y_rd), .y_addr(y_addr),
		.near_direct(1'b0), .near_field(13'h0000), .ptr_in(ptr_in), .wreg_sel(wreg_sel),
		.wreg_we(wreg_we), .wreg_byte(wreg_byte), .sign_extend_op(sign_extend_op),
		.zero_extend_op(zero_extend_op), .wreg_wdata(wreg_wdata), .tbl_op(tbl_op),
		.table_page_pointer(tpp), .prog_req_addr(pra), .pc_q(pc_q),
		.pc_in_vector_q(pc_in_vector_q), .x_rdata_q(x_rdata_q), .y_rdata_q(y_rdata_q),
		.prog_visibility_window_q(pvw_q), .ptr_next_q(ptr_next_q),
		.wreg_rdata_q(wreg_rdata_q), .prog_access_ok_q(pa_ok_q),
		.addr_error_trap_q(addr_error_trap_q));
	dsau_pipe_model #(.MW(MW)) dsau_pipe_model_inst (.sys_clk(sys_clk), .x_req(x_req),
		.y_addr(y_addr), .exp_x(exp_x), .exp_y(exp_y), .exp_ok(exp_ok), .exp_trap(exp_trap));
	task automatic chk(input logic [23:0] g, input logic [23:0] e, input string s);
		n_compared++;
		if (g !== e)
		begin
			fail_count++;
			$display("ERROR %0t %s mismatch", $time, s);
		end
	endtask
	task automatic final_report();
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	assign d = wreg_wdata;
	// Notes are taken at the sampling edge, before the bench's own updates land
	always @(posedge sys_clk)
	begin
		if (srst)
			pc_r <= RESET_PC;
		else if (pc_load)
			pc_r <= pc_target & 24'hFFFFFE;
		else if (pc_advance)
			pc_r <= pc_reverse ? pc_r - PC_STEP : pc_r + PC_STEP;
		tp <= live && exp_trap;
		ok_e <= (pra <= USER_LAST) || (tbl_op && tpp[7]);
		pv_e <= x_req.valid && x_req.effective_address[PVW_BIT];
		xp <= live && x_req.valid && !x_req.wr && exp_ok;
		yp <= live && y_rd;
		if (live && x_req.valid && !x_req.wr && exp_ok)
			xq.push_back(exp_x);
		if (live && y_rd)
			yq.push_back(exp_y);
		pe <= ptr_in + (x_req.byte_op ? STEP_BYTE : STEP_WORD);
		wx <= wr_r[wreg_sel];
		wp <= live && !wreg_we;
		if (wreg_we)
			wr_r[wreg_sel] <= sign_extend_op ? {{8{d[7]}}, d[7:0]} : zero_extend_op ?
				{8'h00, d[7:0]} : wreg_byte ? {wr_r[wreg_sel][15:8], d[7:0]} : d;
	end
	always @(negedge sys_clk)
	begin
		if (xp)
			chk(24'(x_rdata_q), 24'(xq.pop_front()), "x read");
		if (yp)
			chk(24'(y_rdata_q), 24'(yq.pop_front()), "y read");
		if (live)
			chk(24'(addr_error_trap_q), 24'(tp), "trap");
		if (live)
			chk(pc_q, pc_r, "pc");
		if (live)
			chk(24'(ptr_next_q), 24'(pe), "pointer");
		if (wp)
			chk(24'(wreg_rdata_q), 24'(wx), "wreg");
		if (live)
			chk(24'(pa_ok_q), 24'(ok_e), "program access");
		if (live)
			chk(24'(pvw_q), 24'(pv_e), "window flag");
		if (live)
			chk(24'(pc_in_vector_q), 24'((pc_r >= IVT1_FIRST && pc_r <= IVT1_LAST) ||
				(pc_r >= IVT2_FIRST && pc_r <= 24'h0001FF)), "vector");
	end
	initial
	begin
		repeat (6) @(posedge sys_clk);
		srst <= 1'b0;
		for (i = 0; i < 2*MW; i += 2)
		begin
			@(posedge sys_clk);
			x_req <= '{valid: 1'b1, wr: 1'b1, effective_address: 16'(i),
				wdata: 16'($random(seed)), default: '0};
			wreg_sel <= 4'(i / 2);
			wreg_we <= (i < 32);
			wreg_wdata <= 16'($random(seed));
		end
		$display("test memory fill done");
		// Byte writes repeat the byte in both lanes so either lane convention works
		repeat (4000)
		begin
			@(posedge sys_clk);
			live <= 1'b1;
			r = $random(seed);
			r2 = $random(seed);
			x_req <= '{valid: 1'b1, wr: r[11], byte_op: r[12], effective_address:
				{r[8] & r[9] & r[10], 7'h00, r[7:0]}, wdata: r[12] ?
				{2{r2[7:0]}} : r2[15:0], default: '0};
			y_rd <= !r[11];
			y_addr <= {8'h00, r2[23:17], 1'b0};
			pc_load <= r[13] & r[14];
			pc_advance <= r[15];
			pc_reverse <= r[16];
			pc_target <= 24'(r2[25:16]);
			ptr_in <= r2[31:16];
			wreg_sel <= r[20:17];
			wreg_we <= r[21];
			wreg_byte <= r[22];
			sign_extend_op <= r[21] & r[23] & r[24];
			zero_extend_op <= r[21] & r[25] & r[26];
			wreg_wdata <= r2[15:0];
			tbl_op <= r[27];
			tpp <= r2[31:24];
			pra <= {r[28], r2[22:0]};
		end
		@(posedge sys_clk);
		x_req <= '0;
		@(posedge sys_clk);
		live <= 1'b0;
		@(posedge sys_clk);
		$display("test random traffic done");
		final_report();
	end
endmodule // tb_top
`default_nettype wire
